// File: rtl/epab_core.sv
// Purpose: Quadrature pulse emulation of an external encoder plus absolute position and alarm serial sender
// Assumes: step_i/step_dir_i come from encoder interface logic on mclk_i, one strobe per pitch division
// Notes: Edges are metered at the rate ceiling, so excess travel piles up as backlog and raises overspeed
// Notes on behaviour
// - Resolution setting is edges per pitch, clamped to one through 4096.
// - Every pitch travelled yields exactly the set number of A/B edges.
// - Edge rate never exceeds 6.4 Mpps; excess demand raises overspeed alarm.
// - Origin pulse lasts as long as one A-phase pulse.
// - Origin pulse aligns to one selectable A or B rising or falling edge.
// - Rotary absolute encoder: origin pulse only at first origin after power-up.
// - Init: A carries serial then pulses, B pulses; origin line always origin.
// - Host sends sensor-on; serial starts 100 ms later, host counter cleared.
// - Position message is exactly eight characters.
// - About 400 ms after the initial pulse burst, normal pulse output resumes.
// - Serial value is position over resolution, in units of 1048576 pulses.
// - Initial pulse burst carries the remainder, one pulse per 1.48 us.
// - Characters are 9600 bps async: start, seven data, even parity, stop.
// - Message is P, sign, five digits, carriage return; zero sends P+00000.
// - Serial value wraps within -32768 to +32767.
// - Sensor-off with absolute encoder sends the alarm contents on A line.
// - Sensor-off is refused while motor power is on.
// - Forward travel shows B phase leading A phase.
`timescale 1ns/1ns
`default_nettype none
module epab_core
  import epab_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC,
  parameter int WAIT_CYCLES = SENSOR_WAIT_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int PEND_MAX = PEND_LIMIT
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic step_i,
  input wire logic step_dir_i,
  input wire logic enc_origin_i,
  input wire logic [RES_W-1:0] output_resolution_setting_i,
  input wire logic [1:0] origin_edge_sel_i,
  input wire logic abs_mode_i,
  input wire logic rotary_i,
  input wire logic signed [POS_W-1:0] abs_pos_i,
  input wire logic [15:0] alarm_code_i,
  input wire logic motor_power_on_i,
  input wire logic sensor_on_command_i,
  input wire logic sensor_off_command_i,
  output epab_quad_t quad_o,
  output logic overspeed_alarm_o,
  output logic abs_busy_o
);

  function automatic logic [RES_W-1:0] clamp_res(input logic [RES_W-1:0] r);
    if (r < RES_MIN) begin
      return RES_MIN;
    end else if (r > RES_MAX) begin
      return RES_MAX;
    end
    return r;
  endfunction : clamp_res
  function automatic logic [16:0] pow10(input logic [2:0] i);
    case (i)
      3'h0: return 17'h02710;
      3'h1: return 17'h003E8;
      3'h2: return 17'h00064;
      3'h3: return 17'h0000A;
      default: return 17'h00001;
    endcase
  endfunction : pow10
  function automatic logic [6:0] hex_char(input logic [3:0] v);
    return (v < 4'hA) ? (CH_ZERO + {3'h0, v}) : (CH_HEX_OFS + {3'h0, v});
  endfunction : hex_char
  // Character idx of either the position message or the alarm message
  function automatic logic [6:0] msg_char(input logic alm, input logic [2:0] idx, input logic neg,
                                          input logic [19:0] dig, input logic [15:0] code);
    logic [6:0] c;
    c = CH_CR;
    if (alm) begin
      case (idx)
        3'h0: c = CH_A;
        3'h1: c = CH_L;
        3'h2: c = CH_M;
        3'h3: c = hex_char(code[15:12]);
        3'h4: c = hex_char(code[11:8]);
        3'h5: c = hex_char(code[7:4]);
        3'h6: c = hex_char(code[3:0]);
        default: c = CH_CR;
      endcase
    end else begin
      case (idx)
        3'h0: c = CH_P;
        3'h1: c = neg ? CH_MINUS : CH_PLUS;
        3'h2: c = CH_ZERO + {3'h0, dig[19:16]};
        3'h3: c = CH_ZERO + {3'h0, dig[15:12]};
        3'h4: c = CH_ZERO + {3'h0, dig[11:8]};
        3'h5: c = CH_ZERO + {3'h0, dig[7:4]};
        3'h6: c = CH_ZERO + {3'h0, dig[3:0]};
        default: c = CH_CR;
      endcase
    end
    return c;
  endfunction : msg_char
  // Start bit first, seven data bits LSB first, even parity, stop bit
  function automatic logic [9:0] frame(input logic [6:0] ch);
    return {1'b1, ^ch, ch, 1'b0};
  endfunction : frame
  epab_state_t s;
  epab_state_t n;
  logic [RES_W-1:0] res;
  logic [DIV_W:0] sum;
  logic signed [PEND_W-1:0] dlt;
  logic signed [PEND_W-1:0] ped;
  logic edge_go;
  logic edge_fwd;
  logic [1:0] np;
  logic old_a;
  logic old_b;
  logic new_a;
  logic new_b;
  logic matched;
  logic zrise;
  logic [RES_W:0] trial;
  logic [POS_W-1:0] scaled;
  logic [16:0] pw;
  always_comb begin
    n = s;
    res = clamp_res(output_resolution_setting_i);
    sum = '0;
    dlt = '0;
    ped = '0;
    edge_go = 1'b0;
    edge_fwd = 1'b1;
    np = s.ph;
    trial = '0;
    scaled = '0;
    pw = pow10(s.di);
    // Origin input: counted only once the two later stages agree
    n.sy = {s.sy[1:0], enc_origin_i};
    zrise = (s.sy[1] == s.sy[2]) && s.sy[2] && !s.zl;
    if (s.sy[1] == s.sy[2]) begin
      n.zl = s.sy[2];
    end
    // Fractional accumulator: res edges per DIVS_PER_PITCH steps, no drift across pitches
    if (step_i) begin
      if (step_dir_i) begin
        sum = {1'b0, s.acc} + {1'b0, res};
        if (sum >= {1'b0, DIVS_PER_PITCH}) begin
          n.acc = DIV_W'(sum - {1'b0, DIVS_PER_PITCH});
          dlt = 16'sh0001;
        end else begin
          n.acc = DIV_W'(sum);
        end
      end else begin
        if (s.acc >= res) begin
          n.acc = s.acc - res;
        end else begin
          n.acc = s.acc + DIVS_PER_PITCH - res;
          dlt = -16'sh0001;
        end
      end
    end
    if (s.gap != 4'h0) begin
      n.gap = s.gap - 4'h1;
    end
    case (s.st)
      EPAB_ST_NORMAL: begin
        // Backlog drains no faster than one edge per EDGE_CYC cycles
        if (s.gap == 4'h0 && s.pend != '0) begin
          edge_go = 1'b1;
          edge_fwd = ~s.pend[PEND_W-1];
          ped = edge_fwd ? -16'sh0001 : 16'sh0001;
          n.gap = 4'(EDGE_CYC - 1);
        end
        if (sensor_on_command_i && abs_mode_i) begin
          n.st = EPAB_ST_DIV;
          n.dneg = abs_pos_i[POS_W-1];
          n.dq = abs_pos_i[POS_W-1] ? POS_W'(-abs_pos_i) : abs_pos_i;
          n.dr = '0;
          n.dcnt = DIV_STEPS;
          n.alm = 1'b0;
        end else if (sensor_off_command_i && abs_mode_i && !motor_power_on_i) begin
          // Idle mark lead-in first: from a low A phase the first start bit would show no falling edge
          n.st = EPAB_ST_WAIT;
          n.alm = 1'b1;
          n.tmr = '0;
        end
      end
      EPAB_ST_DIV: begin
        if (s.dcnt != 6'h00) begin
          trial = {s.dr[RES_W-1:0], s.dq[POS_W-1]};
          n.dq = {s.dq[POS_W-2:0], 1'b0};
          if (trial >= {1'b0, res}) begin
            trial = trial - {1'b0, res};
            n.dq[0] = 1'b1;
          end
          n.dr = trial;
          n.dcnt = s.dcnt - 6'h01;
        end else begin
          scaled = s.dneg ? POS_W'(-s.dq) : s.dq;
          // Upper bits dropped on purpose: the signed 16-bit value wraps
          n.ser = scaled[SERIAL_SHIFT+15:SERIAL_SHIFT];
          n.icnt = scaled[SERIAL_SHIFT-1:0];
          n.val = scaled[SERIAL_SHIFT+15] ? 17'(-{1'b1, scaled[SERIAL_SHIFT+15:SERIAL_SHIFT]})
                                          : {1'b0, scaled[SERIAL_SHIFT+15:SERIAL_SHIFT]};
          n.di = '0;
          n.dig = '0;
          n.st = EPAB_ST_DIGIT;
        end
      end
      EPAB_ST_DIGIT: begin
        if (s.di == DIGITS) begin
          n.st = EPAB_ST_WAIT;
          n.tmr = '0;
        end else if (s.val >= pw) begin
          n.val = s.val - pw;
          n.dig[4*(4-s.di) +: 4] = s.dig[4*(4-s.di) +: 4] + 4'h1;
        end else begin
          n.di = s.di + 3'h1;
        end
      end
      EPAB_ST_WAIT: begin
        n.tmr = s.tmr + 25'h1;
        if (s.tmr == TMR_W'(WAIT_CYCLES - 1)) begin
          n.st = EPAB_ST_TX;
          n.ci = '0;
          n.bi = '0;
          n.tmr = '0;
          n.sh = frame(msg_char(s.alm, 3'h0, s.ser[15], s.dig, alarm_code_i));
        end
      end
      EPAB_ST_TX: begin
        n.tmr = s.tmr + 25'h1;
        if (s.tmr == TMR_W'(BIT_CYCLES - 1)) begin
          n.tmr = '0;
          n.sh = {1'b1, s.sh[9:1]};
          n.bi = s.bi + 4'h1;
          if (s.bi == FRAME_LAST) begin
            n.bi = '0;
            n.ci = s.ci + 3'h1;
            n.sh = frame(msg_char(s.alm, s.ci + 3'h1, s.ser[15], s.dig, alarm_code_i));
            if (s.ci == MSG_LAST) begin
              n.st = s.alm ? EPAB_ST_NORMAL : EPAB_ST_INIT;
              n.sh = 10'h3FF;
            end
          end
        end
      end
      EPAB_ST_INIT: begin
        if (s.icnt == 20'h00000) begin
          n.st = EPAB_ST_SETTLE;
          n.tmr = '0;
        end else begin
          n.tmr = s.tmr + 25'h1;
          if (s.tmr == TMR_W'(INIT_PULSE_CYC - 1)) begin
            n.tmr = '0;
            n.icnt = s.icnt - 20'h00001;
            edge_go = 1'b1;
            edge_fwd = 1'b1;
          end
        end
      end
      EPAB_ST_SETTLE: begin
        n.tmr = s.tmr + 25'h1;
        if (s.tmr == TMR_W'(SETTLE_CYCLES - 1)) begin
          n.st = EPAB_ST_NORMAL;
        end
      end
      default: begin
        n.st = EPAB_ST_NORMAL;
      end
    endcase
    n.pend = s.pend + dlt + ped;
    if (n.pend > PEND_W'(PEND_MAX) || n.pend < PEND_W'(-PEND_MAX)) begin
      n.ovs = 1'b1;
    end
    // Phase sequence 0,1,3,2 in (a,b): B rises first going forward
    if (edge_go) begin
      np = edge_fwd ? s.ph + 2'h1 : s.ph - 2'h1;
    end
    n.ph = np;
    old_a = s.ph[1];
    old_b = s.ph[1] ^ s.ph[0];
    new_a = np[1];
    new_b = np[1] ^ np[0];
    case (origin_edge_sel_i)
      ORG_A_RISE: matched = !old_a && new_a;
      ORG_A_FALL: matched = old_a && !new_a;
      ORG_B_RISE: matched = !old_b && new_b;
      ORG_B_FALL: matched = old_b && !new_b;
      default: matched = 1'b0;
    endcase
    if (zrise && !(rotary_i && abs_mode_i && s.zdone)) begin
      n.zarm = 1'b1;
    end
    if (edge_go) begin
      if (s.zon) begin
        // Two edges after the start equals one A-phase high or low time
        n.zedges = 1'b1;
        if (s.zedges) begin
          n.zon = 1'b0;
          n.zedges = 1'b0;
        end
      end else if (s.zarm && matched) begin
        n.zon = 1'b1;
        n.zarm = 1'b0;
        n.zedges = 1'b0;
        n.zdone = 1'b1;
      end
    end
    // Serial phases drive A from the frame shifter, held at the idle mark level before it; B stays put
    if (n.st == EPAB_ST_TX) begin
      n.q.a = n.sh[0];
    end else if (n.st == EPAB_ST_DIV || n.st == EPAB_ST_DIGIT || n.st == EPAB_ST_WAIT) begin
      n.q.a = 1'b1;
    end else begin
      n.q.a = np[1];
    end
    n.q.b = np[1] ^ np[0];
    n.q.z = n.zon;
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.st <= EPAB_ST_NORMAL;
      s.sh <= 10'h3FF;
    end else begin
      s <= n;
    end
  end
  assign quad_o = s.q;
  assign overspeed_alarm_o = s.ovs;
  assign abs_busy_o = (s.st != EPAB_ST_NORMAL);
endmodule : epab_core
`default_nettype wire

// File: rtl/epab_pkg.sv
// Purpose: Shared constants and types for the encoder pulse emulator with absolute data sender
// Assumes: 50 MHz system clock
// Notes: Long timing counts are also parameters of the core so a simulation can shorten them
package epab_pkg;
  localparam int CLK_KHZ = 50000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RES_W = 13;
  localparam logic [12:0] RES_MIN = 13'h0001;
  localparam logic [12:0] RES_MAX = 13'h1000;
  localparam int DIV_W = 13;
  localparam logic [12:0] DIVS_PER_PITCH = 13'h1000;
  localparam int MAX_RATE_KPPS = 6400;
  localparam int EDGE_CYC = (CLK_KHZ + MAX_RATE_KPPS - 1) / MAX_RATE_KPPS;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYC = (CLK_KHZ * 1000) / BAUD_BPS;
  localparam int SENSOR_WAIT_MS = 100;
  localparam int SENSOR_WAIT_CYC = SENSOR_WAIT_MS * CLK_KHZ;
  localparam int SETTLE_MS = 400;
  localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
  localparam int INIT_PULSE_NS = 1480;
  localparam int INIT_PULSE_CYC = INIT_PULSE_NS / CLK_PERIOD_NS;
  localparam int SERIAL_SHIFT = 20;
  localparam int POS_W = 40;
  localparam int PEND_W = 16;
  localparam int PEND_LIMIT = 64;
  localparam int TMR_W = 25;
  localparam logic [2:0] MSG_LAST = 3'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [5:0] DIV_STEPS = 6'h28;
  localparam logic [2:0] DIGITS = 3'h5;
  localparam logic [6:0] CH_P = 7'h50;
  localparam logic [6:0] CH_PLUS = 7'h2B;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_HEX_OFS = 7'h37;
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_A = 7'h41;
  localparam logic [6:0] CH_L = 7'h4C;
  localparam logic [6:0] CH_M = 7'h4D;
  localparam logic [1:0] ORG_A_RISE = 2'h0;
  localparam logic [1:0] ORG_A_FALL = 2'h1;
  localparam logic [1:0] ORG_B_RISE = 2'h2;
  localparam logic [1:0] ORG_B_FALL = 2'h3;

  typedef enum logic [6:0] {
    EPAB_ST_NORMAL = 7'h01,
    EPAB_ST_DIV = 7'h02,
    EPAB_ST_DIGIT = 7'h04,
    EPAB_ST_WAIT = 7'h08,
    EPAB_ST_TX = 7'h10,
    EPAB_ST_INIT = 7'h20,
    EPAB_ST_SETTLE = 7'h40
  } epab_st_t;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } epab_quad_t;

  typedef struct packed {
    epab_st_t st;
    logic [2:0] sy;
    logic zl;
    logic [DIV_W-1:0] acc;
    logic signed [PEND_W-1:0] pend;
    logic [3:0] gap;
    logic [1:0] ph;
    logic zarm;
    logic zon;
    logic zedges;
    logic zdone;
    logic ovs;
    logic [TMR_W-1:0] tmr;
    logic [POS_W-1:0] dq;
    logic [RES_W:0] dr;
    logic dneg;
    logic [5:0] dcnt;
    logic [15:0] ser;
    logic [19:0] icnt;
    logic [16:0] val;
    logic [2:0] di;
    logic [19:0] dig;
    logic alm;
    logic [2:0] ci;
    logic [9:0] sh;
    logic [3:0] bi;
    epab_quad_t q;
  } epab_state_t;
endpackage : epab_pkg

// File: dv/epab_host_model.sv
// Purpose: Host controller model: quadrature up/down counter and serial receiver on the A line
// Assumes: Same bit time as the core
// Notes: First line change after a message only resyncs, as A drops from stop level to phase level
`timescale 1ns/1ns
`default_nettype none
module epab_host_model
  import epab_pkg::*;
#(
  parameter int BIT_CYCLES = 8
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire epab_quad_t quad_i,
  input wire logic listen_i,
  output int cnt_o,
  output int zcnt_o,
  output int perr_o,
  output int rxn_o,
  output logic [55:0] rx_o
);
  logic [1:0] idx;
  logic [1:0] idx_q;
  logic pa;
  logic pz;
  logic rsy;
  logic [3:0] ph;
  logic [9:0] bits;
  int t;
  assign idx = {quad_i.a, quad_i.a ^ quad_i.b};
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {cnt_o, zcnt_o, perr_o, rxn_o, t, rx_o, idx_q, pa, pz, rsy, ph, bits} <= '0;
    end else begin
      idx_q <= idx;
      pa <= quad_i.a;
      pz <= quad_i.z;
      // Origin only counted, never clears the position counter
      if (quad_i.z && !pz) zcnt_o <= zcnt_o + 1;
      if (listen_i && rxn_o < 8) begin
        if (ph == 4'h0) begin
          if (pa && !quad_i.a) begin
            ph <= 4'h1;
            t <= BIT_CYCLES / 2;
          end
        end else if (t != 0) begin
          t <= t - 1;
        end else begin
          t <= BIT_CYCLES - 1;
          bits[ph - 4'h1] <= quad_i.a;
          ph <= ph + 4'h1;
          if (ph == 4'hA) begin
            ph <= 4'h0;
            rx_o[rxn_o * 7 +: 7] <= bits[7:1];
            rxn_o <= rxn_o + 1;
            if (bits[0] || !quad_i.a || ^bits[8:1]) perr_o <= perr_o + 1;
            cnt_o <= 0;
            rsy <= 1'b1;
          end
        end
      end else begin
        if (!listen_i) rxn_o <= 0;
        if (idx != idx_q && rsy) rsy <= 1'b0;
        else if (idx - idx_q == 2'h1) cnt_o <= cnt_o + 1;
        else if (idx_q - idx == 2'h1) cnt_o <= cnt_o - 1;
      end
    end
  end
endmodule : epab_host_model
`default_nettype wire

// File: dv/epab_core_asserts.sv
// Purpose: Port-level checks of the pulse emulator and absolute data sender
// Assumes: Bound to every instance of the core
// Notes: Edge spacing is not checked while busy, where the serial bit time or the 1.48 us init pulse period sets the pace
`timescale 1ns/1ns
`default_nettype none
module epab_core_asserts
  import epab_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] origin_edge_sel_i,
  input wire logic abs_mode_i,
  input wire logic rotary_i,
  input wire logic motor_power_on_i,
  input wire logic sensor_on_command_i,
  input wire logic sensor_off_command_i,
  input wire epab_quad_t quad_o,
  input wire logic overspeed_alarm_o,
  input wire logic abs_busy_o
);
  logic [1:0] ze;
  logic [1:0] ab_q;
  logic zseen;
  wire logic [1:0] ab = {quad_o.a, quad_o.b};
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {ze, ab_q, zseen} <= '0;
    end else begin
      ab_q <= ab;
      zseen <= zseen | (quad_o.z & abs_mode_i & rotary_i);
      if (!quad_o.z) ze <= 2'h0;
      else if (ab != ab_q) ze <= ze + 2'h1;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_edge_space: assert property (!abs_busy_o && ab != $past(ab) |=> ($stable(ab) || abs_busy_o) [*7])
    else $error("quadrature edges closer than eight cycles");
  a_quad_gray: assert property (!abs_busy_o && !$past(abs_busy_o) |-> ab != ~$past(ab))
    else $error("A and B changed together");
  a_origin_edge: assert property ($rose(quad_o.z) |-> (origin_edge_sel_i == ORG_A_RISE && $rose(quad_o.a)) ||
      (origin_edge_sel_i == ORG_A_FALL && $fell(quad_o.a)) || (origin_edge_sel_i == ORG_B_RISE && $rose(quad_o.b)) ||
      (origin_edge_sel_i == ORG_B_FALL && $fell(quad_o.b)))
    else $error("origin pulse not on the selected edge");
  a_origin_width: assert property ($fell(quad_o.z) |-> ze == 2'h2 && ab != $past(ab))
    else $error("origin pulse width is not one A pulse");
  a_origin_once: assert property (abs_mode_i && rotary_i && zseen |-> !$rose(quad_o.z))
    else $error("origin pulse repeated in rotary absolute mode");
  a_ovs_sticky: assert property (overspeed_alarm_o |=> overspeed_alarm_o)
    else $error("overspeed alarm dropped");
  a_on_start: assert property (!abs_busy_o && abs_mode_i && sensor_on_command_i |=> ##1 (abs_busy_o && quad_o.a) [*8])
    else $error("sensor-on did not start the sequence with A idle high");
  a_off_refused: assert property (!abs_busy_o && !sensor_on_command_i && sensor_off_command_i &&
      (motor_power_on_i || !abs_mode_i) |=> !abs_busy_o)
    else $error("sensor-off taken while refused");
  a_off_taken: assert property (!abs_busy_o && !sensor_on_command_i && sensor_off_command_i &&
      !motor_power_on_i && abs_mode_i |=> abs_busy_o)
    else $error("sensor-off not taken");
endmodule : epab_core_asserts
bind epab_core epab_core_asserts epab_core_asserts_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .origin_edge_sel_i(origin_edge_sel_i), .abs_mode_i(abs_mode_i), .rotary_i(rotary_i),
  .motor_power_on_i(motor_power_on_i), .sensor_on_command_i(sensor_on_command_i),
  .sensor_off_command_i(sensor_off_command_i), .quad_o(quad_o), .overspeed_alarm_o(overspeed_alarm_o),
  .abs_busy_o(abs_busy_o));
`default_nettype wire

// File: dv/encoder_pulse_out_abs_data_tx_tb_top.sv
// Purpose: Self-checking bench for the pulse emulator and absolute data sender
// Assumes: Shortened bit, wait and settle counts
// Notes: Absolute scenarios start from reset so the phase before the message is known
`timescale 1ns/1ns
`default_nettype none
module encoder_pulse_out_abs_data_tx_tb_top
  import epab_pkg::*;
;
  logic mclk, rst_b, step, dir, org, absm, rot, pwr, son, soff, listen, ovs, busy;
  logic [12:0] res;
  logic [1:0] sel;
  logic signed [39:0] pos;
  logic [15:0] alm;
  logic [55:0] rx;
  epab_quad_t quad;
  int cnt, zcnt, perr, rxn, mismatches, tests_run, cyc;
  epab_core #(.BIT_CYCLES(8), .WAIT_CYCLES(10), .SETTLE_CYCLES(10), .PEND_MAX(64)) epab_core_i (
    .mclk_i(mclk), .rst_b_i(rst_b), .step_i(step), .step_dir_i(dir), .enc_origin_i(org),
    .output_resolution_setting_i(res), .origin_edge_sel_i(sel), .abs_mode_i(absm), .rotary_i(rot),
    .abs_pos_i(pos), .alarm_code_i(alm), .motor_power_on_i(pwr), .sensor_on_command_i(son),
    .sensor_off_command_i(soff), .quad_o(quad), .overspeed_alarm_o(ovs), .abs_busy_o(busy));
  epab_host_model #(.BIT_CYCLES(8)) epab_host_model_i (.mclk_i(mclk), .rst_b_i(rst_b), .quad_i(quad),
    .listen_i(listen), .cnt_o(cnt), .zcnt_o(zcnt), .perr_o(perr), .rxn_o(rxn), .rx_o(rx));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h, want %0h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [55:0] msg(input string s);
    logic [55:0] m;
    for (int k = 0; k < 8; k++) m[k * 7 +: 7] = 7'(s[k]);
    return m;
  endfunction : msg
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask : do_reset
  task automatic steps(input int n, input logic d, input int gap);
    dir <= d;
    if (gap == 0) begin
      step <= 1'b1;
      repeat (n) @(posedge mclk);
      step <= 1'b0;
    end else begin
      repeat (n) begin
        step <= 1'b1;
        @(posedge mclk);
        step <= 1'b0;
        repeat (gap) @(posedge mclk);
      end
    end
    repeat (20) @(posedge mclk);
  endtask : steps
  task automatic wait_idle();
    int k;
    k = 0;
    @(posedge mclk);
    while (busy === 1'b1 && k < 8000) begin
      @(posedge mclk);
      k++;
    end
    check(busy, 1'b0);
  endtask : wait_idle
  task automatic t_pitch();
    int c0;
    c0 = cnt;
    steps(4096, 1'b1, 0);
    check(cnt - c0, 20);
    res <= 13'h0000;
    steps(4096, 1'b0, 0);
    check(cnt - c0, 19);
    res <= 13'h1FFF;
    steps(64, 1'b1, 9);
    check(cnt - c0, 83);
    check(ovs, 1'b0);
    steps(300, 1'b1, 0);
    check(ovs, 1'b1);
  endtask : t_pitch
  task automatic org_pulse();
    org <= 1'b1;
    repeat (6) @(posedge mclk);
    org <= 1'b0;
    steps(12, 1'b1, 9);
  endtask : org_pulse
  task automatic t_origin();
    do_reset();
    res <= 13'h1000;
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      org_pulse();
      check(zcnt, i + 1);
    end
    do_reset();
    absm <= 1'b1;
    rot <= 1'b1;
    org_pulse();
    org_pulse();
    check(zcnt, 1);
    rot <= 1'b0;
  endtask : t_origin
  task automatic t_abs(input logic signed [39:0] p, input logic [12:0] r, input string s, input int n);
    do_reset();
    absm <= 1'b1;
    res <= r;
    pos <= p;
    listen <= 1'b1;
    son <= 1'b1;
    @(posedge mclk);
    son <= 1'b0;
    wait_idle();
    check(rxn, 8);
    check(rx, msg(s));
    check(perr, 0);
    check(cnt, n);
    listen <= 1'b0;
  endtask : t_abs
  task automatic t_alarm();
    do_reset();
    pwr <= 1'b1;
    alm <= 16'hA5C3;
    listen <= 1'b1;
    soff <= 1'b1;
    @(posedge mclk);
    soff <= 1'b0;
    repeat (20) @(posedge mclk);
    check(busy, 1'b0);
    pwr <= 1'b0;
    soff <= 1'b1;
    @(posedge mclk);
    soff <= 1'b0;
    wait_idle();
    check(rx, msg("ALMA5C3\015"));
    check(rxn, 8);
    check(perr, 0);
    listen <= 1'b0;
  endtask : t_alarm
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc == 40000) begin
        mismatches++;
        wrap_up();
      end
    end
  end
  initial begin
    {rst_b, step, dir, org, absm, rot, pwr, son, soff, listen, sel, alm, pos} = '0;
    res = 13'h0014;
    mismatches = 0;
    tests_run = 0;
    do_reset();
    check({quad, ovs, busy}, 5'h00);
    t_pitch();
    t_origin();
    t_abs(40'h0C0E40001C, 13'h0004, "P+12345\015", 7);
    t_abs(40'hFFFFE00000, 13'h0001, "P-00002\015", 0);
    t_abs(40'h0800000000, 13'h0001, "P-32768\015", 0);
    t_alarm();
    wrap_up();
  end
endmodule : encoder_pulse_out_abs_data_tx_tb_top
`default_nettype wire
